// >>> lan_status_regs.vh
// Constants for the LAN status, interrupt-mask and diagnostic register bank.
// Assumes inclusion by the register bank modules only.
`ifndef LAN_STATUS_REGS_VH
`define LAN_STATUS_REGS_VH

// -----------------------------------------------------------------------------
// Register offsets within the I/O block
// -----------------------------------------------------------------------------
`define OFS_STATUS 4'h0
`define OFS_MASK 4'h0
`define OFS_DIAG 4'h1
`define OFS_COMMAND 4'h1
`define OFS_NODE_ID 4'h5

// -----------------------------------------------------------------------------
// Status bit positions, shared by the mask
// -----------------------------------------------------------------------------
`define BIT_RI 7
`define BIT_POR 4
`define BIT_TEST 3
`define BIT_NET_RESHUFFLE_FLAG 2
`define BIT_TMA 1
`define BIT_TA 0

// -----------------------------------------------------------------------------
// Diagnostic bit positions
// -----------------------------------------------------------------------------
`define BIT_SELF_RESHUFFLE 7
`define BIT_RCV_ACT 5
`define BIT_TOKEN_SEEN 4

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define MASK_RESET 8'h00
`define NODE_ID_ZERO 8'h00

// -----------------------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------------------
`define CMD_CLEAR_TX_INT 8'h00
`define CMD_DISABLE_TX 8'h01
`define CMD_DISABLE_RX 8'h02
`define CMD_SEND_LOW 3'h3
`define CMD_RECV_LOW 3'h4
`define CMD_CLEAR_FLAGS_LOW 3'h6

// -----------------------------------------------------------------------------
// Line idle timing
// -----------------------------------------------------------------------------
`define LINE_IDLE_NS 82000
`define CLK_PERIOD_NS 20
`define LINE_IDLE_CYCLES (`LINE_IDLE_NS / `CLK_PERIOD_NS)

`endif

// >>> line_idle_timer.v
// Line idle timer: pulses once when the receive line has been quiet long
// enough. Assumes line_receive_input is synchronous to ref_clk.
`timescale 1ns/1ps
`include "lan_status_regs.vh"
module line_idle_timer #(
  parameter IDLE_CYCLES = `LINE_IDLE_CYCLES
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Line
  input wire line_receive_input,
  // Result
  output reg idle_expired_ff,
  output reg activity_ff
);

  reg [12:0] count_ff;
  reg prev_line_ff;
  reg prev_valid_ff;
  wire edge_seen;

  // The line level is unknown right after reset, so the first sample only
  // primes the detector; a high idle line would otherwise look like activity.
  assign edge_seen = prev_valid_ff & (line_receive_input ^ prev_line_ff);

  // ---------------------------------------------------------------------------
  // Counter restarts on every line transition and fires once at the limit.
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      count_ff <= 13'h0000;
      prev_line_ff <= 1'b0;
      prev_valid_ff <= 1'b0;
      idle_expired_ff <= 1'b0;
      activity_ff <= 1'b0;
    end else begin
      prev_line_ff <= line_receive_input;
      prev_valid_ff <= 1'b1;
      activity_ff <= edge_seen;
      idle_expired_ff <= 1'b0;
      if (edge_seen) begin
        count_ff <= 13'h0000;
      end else if (count_ff == IDLE_CYCLES[12:0] - 13'h0001) begin
        count_ff <= count_ff + 13'h0001;
        idle_expired_ff <= 1'b1;
      end else if (count_ff < IDLE_CYCLES[12:0]) begin
        count_ff <= count_ff + 13'h0001;
      end
    end
  end

endmodule // line_idle_timer

// >>> command_decoder.v
// Command decoder: turns a host write of the command location into
// one-cycle strobes. Assumes a single-cycle write strobe.
`timescale 1ns/1ps
module command_decoder (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Host write
  input wire cmd_write,
  input wire [7:0] cmd_data,
  // Strobes
  output reg start_send_page_cmd,
  output reg arm_receive_page_cmd,
  output reg clear_flags_cmd,
  output reg disable_tx_cmd,
  output reg disable_rx_cmd,
  output reg [1:0] page_ff,
  output reg accept_broadcast_ff
);
`include "lan_status_regs.vh"

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      start_send_page_cmd <= 1'b0;
      arm_receive_page_cmd <= 1'b0;
      clear_flags_cmd <= 1'b0;
      disable_tx_cmd <= 1'b0;
      disable_rx_cmd <= 1'b0;
      page_ff <= 2'h0;
      accept_broadcast_ff <= 1'b0;
    end else begin
      start_send_page_cmd <= cmd_write && cmd_data[7:5] == 3'h0 &&
        cmd_data[2:0] == `CMD_SEND_LOW;
      arm_receive_page_cmd <= cmd_write && cmd_data[6:5] == 2'h0 &&
        cmd_data[2:0] == `CMD_RECV_LOW;
      clear_flags_cmd <= cmd_write &&
        cmd_data[2:0] == `CMD_CLEAR_FLAGS_LOW;
      disable_tx_cmd <= cmd_write && cmd_data == `CMD_DISABLE_TX;
      disable_rx_cmd <= cmd_write && cmd_data == `CMD_DISABLE_RX;
      if (cmd_write) begin
        page_ff <= cmd_data[4:3];
        if (cmd_data[2:0] == `CMD_RECV_LOW) begin
          accept_broadcast_ff <= cmd_data[7];
        end
      end
    end
  end

endmodule // command_decoder

// >>> lan_status_interrupt_regs.v
// Status, interrupt mask and diagnostic status bank of a token-passing LAN
// controller. Assumes the host I/O decode gives one-cycle read and write
// strobes, and the protocol engine gives one-cycle event pulses.
//
// Overview of operation
// - Mask bit shares its status flag position.
// - Acknowledge flag never raises the interrupt.
// - Interrupt is OR of three masked flags.
// - Masking hides but keeps the pending flag.
// - Reshuffle flag cleared only by clear-flags.
// - Any reset zeroes the mask.
// - Diagnostic bits clear on read and reset.
// - Diagnostic reads low in bits 7,5,4 after reset.
// - Command write starts the selected command.
// - Receive inhibited sets on stored packet.
// - Power-on flag sets on resets, node zero.
// - Test flag reads zero.
// - Reshuffle sets after 82 us line idle.
// - Acknowledged sets on positive acknowledge only.
// - Transmit available sets on completion, disable.
// - Status bits 6 and 5 carry nothing.
// - Send command clears available and acknowledged.
// - Receive command clears receive inhibited.
`timescale 1ns/1ps
module lan_status_interrupt_regs (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  input wire soft_reset,
  // Host I/O access
  input wire [3:0] io_addr,
  input wire io_read,
  input wire io_write,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_ff,
  // Protocol engine events
  input wire packet_stored,
  input wire send_done,
  input wire send_acked,
  input wire send_was_broadcast,
  input wire token_arrived,
  input wire foreign_token_seen,
  input wire token_timer_expired,
  input wire line_receive_input,
  // Status toward the protocol engine
  output reg receive_enabled_ff,
  output reg send_pending_ff,
  output reg [1:0] send_page_ff,
  output reg [1:0] recv_page_ff,
  output reg accept_broadcast_ff,
  // Host interrupt
  output reg host_interrupt_out
);
`include "lan_status_regs.vh"

  reg [7:0] interrupt_enable_mask;
  reg receive_inhibited;
  reg power_on_flag;
  reg net_reshuffle_flag;
  reg transmit_acknowledged;
  reg transmit_available;
  reg self_caused_reshuffle;
  reg recv_activity_ff;
  reg token_seen_ff;
  reg disable_tx_wait_ff;
  reg disable_rx_wait_ff;
  wire any_reset;
  wire cmd_write;
  wire start_send_page_cmd;
  wire arm_receive_page_cmd;
  wire clear_flags_cmd;
  wire disable_tx_cmd;
  wire disable_rx_cmd;
  wire [1:0] cmd_page;
  wire cmd_broadcast;
  wire idle_expired;
  wire line_activity;
  wire diag_read;
  wire node_zero_write;
  wire [7:0] status_word;
  wire [7:0] diag_word;
  wire nxt_interrupt;
  wire status_read;
  wire [7:0] masked_term;

  // Only these status positions may interrupt; the acknowledge flag and
  // the power-on flag share the mask layout but never raise the line.
  localparam [7:0] INT_SOURCES = (8'h01 << `BIT_RI) |
    (8'h01 << `BIT_NET_RESHUFFLE_FLAG) |
    (8'h01 << `BIT_TA);

  // Hardware and software reset act alike on every register of the bank.
  assign any_reset = rst | soft_reset;
  assign cmd_write = io_write && io_addr == `OFS_COMMAND;
  assign status_read = io_read && io_addr == `OFS_STATUS;
  assign diag_read = io_read && io_addr == `OFS_DIAG;
  assign node_zero_write = io_write && io_addr == `OFS_NODE_ID &&
    io_wdata == `NODE_ID_ZERO;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Both helpers take the combined reset, so a software reset also drops
  // any strobe in flight and restarts the idle count.
  command_decoder u_cmd (
    .ref_clk(ref_clk),
    .rst(any_reset),
    .cmd_write(cmd_write),
    .cmd_data(io_wdata),
    .start_send_page_cmd(start_send_page_cmd),
    .arm_receive_page_cmd(arm_receive_page_cmd),
    .clear_flags_cmd(clear_flags_cmd),
    .disable_tx_cmd(disable_tx_cmd),
    .disable_rx_cmd(disable_rx_cmd),
    .page_ff(cmd_page),
    .accept_broadcast_ff(cmd_broadcast)
  );

  line_idle_timer u_idle (
    .ref_clk(ref_clk),
    .rst(any_reset),
    .line_receive_input(line_receive_input),
    .idle_expired_ff(idle_expired),
    .activity_ff(line_activity)
  );

  // ---------------------------------------------------------------------------
  // Interrupt mask
  // ---------------------------------------------------------------------------
  // The mask is write-only; software must keep its own copy of it.
  always @(posedge ref_clk) begin
    if (any_reset) begin
      interrupt_enable_mask <= `MASK_RESET;
    end else if (io_write && io_addr == `OFS_MASK) begin
      interrupt_enable_mask <= io_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags; a setting event wins over a clear in the same cycle.
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (any_reset) begin
      receive_inhibited <= 1'b1;
      power_on_flag <= 1'b1;
      net_reshuffle_flag <= 1'b0;
      transmit_acknowledged <= 1'b0;
      transmit_available <= 1'b1;
      receive_enabled_ff <= 1'b0;
      send_pending_ff <= 1'b0;
      send_page_ff <= 2'h0;
      recv_page_ff <= 2'h0;
      accept_broadcast_ff <= 1'b0;
      disable_tx_wait_ff <= 1'b0;
      disable_rx_wait_ff <= 1'b0;
    end else begin
      // Receive side. A stored packet outranks a receive command in the
      // same cycle, so the host still sees the flag and re-arms later.
      // A disable waits for the token, as a reception may still be busy.
      if (packet_stored && receive_enabled_ff) begin
        receive_inhibited <= 1'b1;
        receive_enabled_ff <= 1'b0;
      end else if (disable_rx_wait_ff && token_arrived) begin
        receive_inhibited <= 1'b1;
        disable_rx_wait_ff <= 1'b0;
      end else if (arm_receive_page_cmd) begin
        receive_inhibited <= 1'b0;
        receive_enabled_ff <= 1'b1;
        recv_page_ff <= cmd_page;
        accept_broadcast_ff <= cmd_broadcast;
      end else if (disable_rx_cmd) begin
        receive_enabled_ff <= 1'b0;
        disable_rx_wait_ff <= 1'b1;
      end
      // Power-on flag. Writing a zero node identifier marks the node as
      // freshly started, just as a reset does.
      if (node_zero_write) begin
        power_on_flag <= 1'b1;
      end else if (clear_flags_cmd) begin
        power_on_flag <= 1'b0;
      end
      // Reshuffle flag. Only the clear-flags command removes it, so a
      // masked reshuffle stays visible to a polling host.
      if (idle_expired) begin
        net_reshuffle_flag <= 1'b1;
      end else if (clear_flags_cmd) begin
        net_reshuffle_flag <= 1'b0;
      end
      // Transmit side. Completion and acknowledge only count while a send
      // is pending, so a late pulse cannot mark an idle transmitter.
      // A disable waits for the token before the transmitter is freed.
      if (send_acked && send_pending_ff && !send_was_broadcast) begin
        transmit_acknowledged <= 1'b1;
      end else if (start_send_page_cmd) begin
        transmit_acknowledged <= 1'b0;
      end
      if (send_done && send_pending_ff) begin
        transmit_available <= 1'b1;
        send_pending_ff <= 1'b0;
      end else if (disable_tx_wait_ff && token_arrived) begin
        transmit_available <= 1'b1;
        disable_tx_wait_ff <= 1'b0;
      end else if (start_send_page_cmd) begin
        transmit_available <= 1'b0;
        send_pending_ff <= 1'b1;
        send_page_ff <= cmd_page;
      end else if (disable_tx_cmd) begin
        send_pending_ff <= 1'b0;
        disable_tx_wait_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Diagnostic bits: cleared by a read unless an event lands that cycle.
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (any_reset) begin
      self_caused_reshuffle <= 1'b0;
      recv_activity_ff <= 1'b0;
      token_seen_ff <= 1'b0;
    end else begin
      if (token_timer_expired) begin
        self_caused_reshuffle <= 1'b1;
      end else if (diag_read) begin
        self_caused_reshuffle <= 1'b0;
      end
      if (line_activity) begin
        recv_activity_ff <= 1'b1;
      end else if (diag_read) begin
        recv_activity_ff <= 1'b0;
      end
      if (foreign_token_seen) begin
        token_seen_ff <= 1'b1;
      end else if (diag_read) begin
        token_seen_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read data and interrupt
  // ---------------------------------------------------------------------------
  // Unused positions read as zero rather than floating values.
  assign status_word[`BIT_RI] = receive_inhibited;
  assign status_word[6:5] = 2'b00;
  assign status_word[`BIT_POR] = power_on_flag;
  assign status_word[`BIT_TEST] = 1'b0;
  assign status_word[`BIT_NET_RESHUFFLE_FLAG] = net_reshuffle_flag;
  assign status_word[`BIT_TMA] = transmit_acknowledged;
  assign status_word[`BIT_TA] = transmit_available;

  assign diag_word[`BIT_SELF_RESHUFFLE] = self_caused_reshuffle;
  assign diag_word[6] = 1'b0;
  assign diag_word[`BIT_RCV_ACT] = recv_activity_ff;
  assign diag_word[`BIT_TOKEN_SEEN] = token_seen_ff;
  assign diag_word[3:0] = 4'h0;

  // Each status flag meets the mask bit at its own position.
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_term
      assign masked_term[bit_idx] = INT_SOURCES[bit_idx] &
        status_word[bit_idx] & interrupt_enable_mask[bit_idx];
    end
  endgenerate

  // A masked flag keeps its state, so the line returns with the mask.
  assign nxt_interrupt = |masked_term;

  always @(posedge ref_clk) begin
    if (any_reset) begin
      io_rdata_ff <= 8'h00;
      host_interrupt_out <= 1'b0;
    end else begin
      host_interrupt_out <= nxt_interrupt;
      // Read data falls back to zero so a stale byte is never reread.
      if (status_read) begin
        io_rdata_ff <= status_word;
      end else if (diag_read) begin
        io_rdata_ff <= diag_word;
      end else begin
        io_rdata_ff <= 8'h00;
      end
    end
  end

endmodule // lan_status_interrupt_regs

// >>> host_model.sv
// Host processor model: byte reads and writes on the I/O strobes.
// Assumes the bench calls its tasks and a free-running ref_clk.
`timescale 1ns/1ps
module host_model (
  // Bus
  input wire ref_clk,
  input wire [7:0] io_rdata_ff,
  output logic [3:0] io_addr,
  output logic io_read,
  output logic io_write,
  output logic [7:0] io_wdata
);
  initial begin
    io_addr = 4'h0;
    io_read = 1'b0;
    io_write = 1'b0;
    io_wdata = 8'h5a;
  end

  // Released data is inverted so a stale byte is never mistaken for a write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_write = 1'b1;
    @(negedge ref_clk);
    io_write = 1'b0;
    io_wdata = ~d;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_read = 1'b1;
    @(negedge ref_clk);
    d = io_rdata_ff;
    io_read = 1'b0;
  endtask
endmodule // host_model

// >>> lan_status_checker.sv
// Port checker of the status and interrupt bank.
// Assumes it is bound to the bank; one clock domain.
`timescale 1ns/1ps
module lan_status_checker (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  input wire soft_reset,
  // Host access
  input wire [3:0] io_addr,
  input wire io_read,
  input wire io_write,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata_ff,
  // Events and state
  input wire send_done,
  input wire token_arrived,
  input wire receive_enabled_ff,
  input wire send_pending_ff,
  input wire [1:0] send_page_ff,
  input wire [1:0] recv_page_ff,
  input wire accept_broadcast_ff,
  input wire host_interrupt_out
);
  logic [7:0] mask_ff;
  wire any_rst = rst | soft_reset;
  wire wr_mask = io_write && io_addr == 4'h0;
  wire wr_cmd = io_write && io_addr == 4'h1;

  // Shadow of the write-only mask, loaded on the same edge as the bank's.
  always @(posedge ref_clk) begin
    if (any_rst)
      mask_ff <= 8'h00;
    else if (wr_mask)
      mask_ff <= io_wdata;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (any_rst);

  sequence send_cmd_s;
    wr_cmd && io_wdata[7:5] == 3'b000 && io_wdata[2:0] == 3'b011;
  endsequence

  a_reset_int_low: assert property (
    $past(any_rst) |-> !host_interrupt_out)
    else $error("interrupt high just after reset");
  a_soft_clear: assert property (disable iff (rst)
    soft_reset |=> !receive_enabled_ff && !send_pending_ff)
    else $error("soft reset left engine state set");
  a_tma_no_int: assert property (
    $past(mask_ff & 8'h85) == 8'h00 |-> !host_interrupt_out)
    else $error("interrupt without an enabled source");
  a_mask_hide: assert property (
    wr_mask && (io_wdata & 8'h85) == 8'h00 |=> ##1 !host_interrupt_out)
    else $error("cleared mask did not hide interrupt");
  a_status_zero: assert property ($past(io_read && io_addr == 4'h0)
    |-> io_rdata_ff[6:5] == 2'b00 && !io_rdata_ff[3])
    else $error("unused status bits not zero");
  a_diag_zero: assert property ($past(io_read && io_addr == 4'h1)
    |-> io_rdata_ff[6] == 1'b0 && io_rdata_ff[3:0] == 4'h0)
    else $error("unused diagnostic bits not zero");
  a_idle_rdata: assert property (
    !$past(io_read) |-> io_rdata_ff == 8'h00)
    else $error("read data not zero between reads");
  a_send_page: assert property (
    send_cmd_s |-> ##2 send_page_ff == $past(io_wdata[4:3], 2))
    else $error("send page not taken from command");
  a_recv_page: assert property (
    wr_cmd && io_wdata[6:5] == 2'b00 && io_wdata[2:0] == 3'b100 |-> ##2
    {accept_broadcast_ff, recv_page_ff} ==
    $past({io_wdata[7], io_wdata[4:3]}, 2))
    else $error("receive page or broadcast not taken");
  a_send_clear_int: assert property (
    send_cmd_s ##1 (mask_ff == 8'h01 && !send_done && !token_arrived)[*2]
    |=> !host_interrupt_out)
    else $error("send command left transmit interrupt");

  c_send: cover property (send_cmd_s);
  c_reshuffle_int: cover property (host_interrupt_out && mask_ff == 8'h04);
  c_diag_set: cover property ($past(io_read && io_addr == 4'h1) &&
    io_rdata_ff != 8'h00);
endmodule // lan_status_checker

// >>> test_lan_status_interrupt_regs.sv
// Self-checking bench of the status and interrupt bank.
// Assumes host_model and lan_status_checker are compiled first.
`timescale 1ns/1ps
module test_lan_status_interrupt_regs;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_reset = 1'b0;
  logic [5:0] ev = 6'h00;
  logic bcast = 1'b0;
  logic line_in = 1'b0;
  logic [7:0] d;
  wire [3:0] io_addr;
  wire io_read;
  wire io_write;
  wire [7:0] io_wdata;
  wire [7:0] io_rdata_ff;
  wire rx_en;
  wire tx_pend;
  wire acc_b;
  wire irq;
  wire [1:0] tx_pg;
  wire [1:0] rx_pg;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  // Rows hold the expected interrupt above the mask byte.
  logic [8:0] rows [0:7] = '{9'h185, 9'h180, 9'h000, 9'h180, 9'h101,
                             9'h004, 9'h002, 9'h07a};

  always #10 ref_clk = ~ref_clk;

  host_model u_host (.ref_clk(ref_clk), .io_rdata_ff(io_rdata_ff),
    .io_addr(io_addr), .io_read(io_read), .io_write(io_write),
    .io_wdata(io_wdata));

  lan_status_interrupt_regs i_dut (.ref_clk(ref_clk), .rst(rst),
    .soft_reset(soft_reset), .io_addr(io_addr), .io_read(io_read),
    .io_write(io_write), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
    .packet_stored(ev[0]), .send_done(ev[1]), .send_acked(ev[2]),
    .send_was_broadcast(bcast), .token_arrived(ev[3]),
    .foreign_token_seen(ev[4]), .token_timer_expired(ev[5]),
    .line_receive_input(line_in), .receive_enabled_ff(rx_en),
    .send_pending_ff(tx_pend), .send_page_ff(tx_pg), .recv_page_ff(rx_pg),
    .accept_broadcast_ff(acc_b), .host_interrupt_out(irq));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pulse(input logic [5:0] e);
    @(negedge ref_clk);
    ev = e;
    @(negedge ref_clk);
    ev = 6'h00;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic rs(input logic [7:0] exp);
    u_host.rd(4'h0, d);
    chk(d, exp);
  endtask

  task automatic rdg(input logic [7:0] exp);
    u_host.rd(4'h1, d);
    chk(d, exp);
  endtask

  task automatic close_out;
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    rs(8'h91);
    rdg(8'h00);
    for (int i = 0; i < 8; i++) begin
      u_host.wr(4'h0, rows[i][7:0]);
      chk({7'h0, irq}, {7'h0, rows[i][8]});
    end
    rs(8'h91);
    u_host.wr(4'h0, 8'h02);
    u_host.wr(4'h1, 8'h1b);
    rs(8'h90);
    chk({6'h0, tx_pg}, 8'h03);
    pulse(6'h04);
    pulse(6'h02);
    rs(8'h93);
    chk({7'h0, irq}, 8'h00);
    u_host.wr(4'h0, 8'h01);
    chk({7'h0, irq}, 8'h01);
    u_host.wr(4'h1, 8'h03);
    bcast = 1'b1;
    pulse(6'h04);
    bcast = 1'b0;
    pulse(6'h02);
    rs(8'h91);
    u_host.wr(4'h1, 8'h8c);
    rs(8'h11);
    chk({5'h0, acc_b, rx_pg}, 8'h05);
    pulse(6'h01);
    rs(8'h91);
    u_host.wr(4'h1, 8'h06);
    rs(8'h81);
    u_host.wr(4'h5, 8'h00);
    rs(8'h91);
    u_host.wr(4'h1, 8'h1b);
    u_host.wr(4'h1, 8'h01);
    pulse(6'h08);
    rs(8'h91);
    pulse(6'h30);
    line_in = 1'b1;
    repeat (3) @(negedge ref_clk);
    rdg(8'hb0);
    rdg(8'h00);
    u_host.wr(4'h0, 8'h85);
    pulse(6'h10);
    soft_reset = 1'b1;
    @(negedge ref_clk);
    soft_reset = 1'b0;
    rs(8'h91);
    chk({7'h0, irq}, 8'h00);
    rdg(8'h00);
    u_host.wr(4'h0, 8'h04);
    line_in = 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(8'(n > 4095 && n < 4110), 8'h01);
    if (n == 5000)
      close_out();
    rdg(8'h20);
    rs(8'h95);
    u_host.wr(4'h1, 8'h06);
    @(negedge ref_clk);
    chk({7'h0, irq}, 8'h00);
    close_out();
  end
endmodule // test_lan_status_interrupt_regs

bind lan_status_interrupt_regs lan_status_checker u_chk (.ref_clk(ref_clk),
  .rst(rst), .soft_reset(soft_reset), .io_addr(io_addr), .io_read(io_read),
  .io_write(io_write), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
  .send_done(send_done), .token_arrived(token_arrived),
  .receive_enabled_ff(receive_enabled_ff), .send_pending_ff(send_pending_ff),
  .send_page_ff(send_page_ff), .recv_page_ff(recv_page_ff),
  .accept_broadcast_ff(accept_broadcast_ff),
  .host_interrupt_out(host_interrupt_out));
